// *** hdl/icw_pkg.sv ***
// package: constants and types for the indirect csr window and page attribute table
package icw_pkg;
  localparam logic [7:0] WINDOW_OFFSET = 8'h5C;
  localparam logic [7:0] PAGE_PORT_OFFSET = 8'h58;
  localparam int WIN_DATA_LSB = 14;
  localparam int WIN_DATA_W = 18;
  localparam int WIN_WRITE_BIT = 7;
  localparam int WIN_RSVD_BIT = 6;
  localparam int SEL_W = 6;
  localparam int PAGE_RW_BIT = 4;
  localparam int PAGE_PAR_BIT = 3;
  localparam int PAGE_LOCK_BIT = 2;
  localparam int PAGE_ADDR_LSB = 9;
  localparam logic [5:0] SEL_RANGE_EN = 6'h05;
  localparam logic [5:0] SEL_DIAG = 6'h06;
  localparam logic [5:0] SEL_FAIL_DATA = 6'h07;
  localparam logic [5:0] SEL_XLAT_BASE = 6'h20;
  localparam int RANGE_EXT_BIT = 26 - WIN_DATA_LSB;
  localparam int RANGE_STD_BIT = 25 - WIN_DATA_LSB;
  localparam logic [13:0] WINDOW_RESET = 14'h0000;
  // byte swap modes
  typedef enum logic [1:0] {
    ICW_SWAP_NONE = 2'h0,
    ICW_SWAP_BYTE = 2'h1,
    ICW_SWAP_WORD = 2'h2,
    ICW_SWAP_LONG = 2'h3
  } icw_swap_e;
  // attributes of one page as stored in the table
  typedef struct packed {
    logic parity;
    logic normalRead;
    icw_swap_e swap;
  } icw_page_s;
  // vme access address-space class
  typedef enum logic [1:0] {
    ICW_AS_EXT = 2'h0,
    ICW_AS_BAD = 2'h1,
    ICW_AS_SHORT = 2'h2,
    ICW_AS_STD = 2'h3
  } icw_space_e;
endpackage

// *** hdl/icw_window.sv ***
// module: indirect register window and per-page read and swap attribute table
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - lock attribute set: vme reads pass plain
// - lock attribute clear: vme reads become interlocked
// - apply two-bit page swap code to transfers
// - write flag set loads bits 31:14
// - write flag clear leaves target untouched
// - flagged read: target high, window low
// - unimplemented select reads all zeros
// - codes 5,6,7 reach enable, diag, fail
// - codes 20-3F reach translation registers 0-31
// - codes 0-4, 8-1F are reserved
// - range enable gates only vme transfers
// - never answer short-address vme accesses
// - window at 5C, bit 6 reads zero
// - store even parity with page attributes
module icw_window #(
  parameter int PAGE_AW = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // host register port
  input wire logic regValid,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regRvalid,
  // vme slave request classification
  input wire logic vmeValid,
  input wire logic vmeRead,
  input wire icw_pkg::icw_space_e vmeSpace,
  input wire logic vmeAddrHigh,
  input wire logic [PAGE_AW-1:0] vmePage,
  output logic vmeAccept,
  output logic hostLockedRead,
  output logic hostPlainRead,
  output icw_pkg::icw_swap_e vmeSwap,
  // failing data capture source
  input wire logic [17:0] failData,
  // translation and diagnostic register contents for the cpu path
  output logic [32*18-1:0] xlatFlat,
  output logic [17:0] diagBits
);
  logic [13:0] window_reg;
  logic [17:0] rangeEn_reg;
  logic [17:0] diag_reg;
  logic [17:0] xlat_reg [32];
  icw_pkg::icw_page_s page_mem [2**PAGE_AW];
  logic [PAGE_AW-1:0] pageSel_reg;
  logic winWr;
  logic pageWr;
  logic [5:0] sel;
  logic flag;
  logic [17:0] target;
  logic targetOk;
  icw_pkg::icw_page_s pageNow;

  // even parity over the three attribute bits
  function automatic logic evenPar(input logic [2:0] a);
    evenPar = ^a;
  endfunction

  assign winWr = regValid && regWrite && (regAddr == icw_pkg::WINDOW_OFFSET);
  assign pageWr = regValid && regWrite && (regAddr == icw_pkg::PAGE_PORT_OFFSET);
  assign sel = window_reg[icw_pkg::SEL_W-1:0];
  assign flag = window_reg[icw_pkg::WIN_WRITE_BIT];

  // window register: select and flag taken in one write, bit 6 kept zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      window_reg <= icw_pkg::WINDOW_RESET;
    end else if (winWr) begin
      window_reg <= {regWdata[13:8], regWdata[7], 1'b0, regWdata[5:0]};
    end
  end

  // indirect targets load only with the write flag set
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rangeEn_reg <= 18'h00000;
      diag_reg <= 18'h00000;
      for (int i = 0; i < 32; i++) begin
        xlat_reg[i] <= 18'h00000;
      end
    end else if (winWr && regWdata[icw_pkg::WIN_WRITE_BIT]) begin
      if (regWdata[5:0] == icw_pkg::SEL_RANGE_EN) begin
        rangeEn_reg <= regWdata[31:14];
      end
      if (regWdata[5:0] == icw_pkg::SEL_DIAG) begin
        diag_reg <= regWdata[31:14];
      end
      if (regWdata[5] == 1'b1) begin
        xlat_reg[regWdata[4:0]] <= regWdata[31:14];
      end
    end
  end

  // select decode; reserved codes give no target
  always_comb begin
    target = 18'h00000;
    targetOk = 1'b0;
    if (sel[5]) begin
      target = xlat_reg[sel[4:0]];
      targetOk = 1'b1;
    end else if (sel == icw_pkg::SEL_RANGE_EN) begin
      target = rangeEn_reg;
      targetOk = 1'b1;
    end else if (sel == icw_pkg::SEL_DIAG) begin
      target = diag_reg;
      targetOk = 1'b1;
    end else if (sel == icw_pkg::SEL_FAIL_DATA) begin
      target = failData;
      targetOk = 1'b1;
    end
  end

  // page table writes with parity, and read address latch
  always_ff @(posedge ref_clk) begin
    if (pageWr) begin
      pageSel_reg <= regWdata[icw_pkg::PAGE_ADDR_LSB +: PAGE_AW];
      if (regWdata[icw_pkg::PAGE_RW_BIT]) begin
        page_mem[regWdata[icw_pkg::PAGE_ADDR_LSB +: PAGE_AW]] <=
          {evenPar(regWdata[2:0]), regWdata[2], icw_pkg::icw_swap_e'(regWdata[1:0])};
      end
    end
  end

  // read return, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      regRdata <= 32'h00000000;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regValid && !regWrite;
      regRdata <= 32'h00000000;
      if (regValid && !regWrite && regAddr == icw_pkg::WINDOW_OFFSET) begin
        if (!targetOk) begin
          regRdata <= 32'h00000000;
        end else if (flag) begin
          regRdata <= {target, window_reg};
        end else begin
          regRdata <= {target, 14'h0000};
        end
      end else if (regValid && !regWrite && regAddr == icw_pkg::PAGE_PORT_OFFSET) begin
        regRdata <= {28'h0000000, page_mem[pageSel_reg]};
      end
    end
  end

  // vme side: address classes, lock and swap attributes
  assign pageNow = page_mem[vmePage];
  always_comb begin
    vmeAccept = 1'b0;
    unique case (vmeSpace)
      icw_pkg::ICW_AS_EXT: vmeAccept = vmeValid && rangeEn_reg[icw_pkg::RANGE_EXT_BIT]
                                       && !vmeAddrHigh;
      icw_pkg::ICW_AS_STD: vmeAccept = vmeValid && rangeEn_reg[icw_pkg::RANGE_STD_BIT]
                                       && !vmeAddrHigh;
      icw_pkg::ICW_AS_SHORT: vmeAccept = 1'b0;
      icw_pkg::ICW_AS_BAD: vmeAccept = 1'b0;
    endcase
  end
  assign hostPlainRead = vmeAccept && vmeRead && pageNow.normalRead;
  assign hostLockedRead = vmeAccept && vmeRead && !pageNow.normalRead;
  assign vmeSwap = vmeAccept ? pageNow.swap : icw_pkg::ICW_SWAP_NONE;

  // translation registers exported flat
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      xlatFlat[i*18 +: 18] = xlat_reg[i];
    end
  end
  assign diagBits = diag_reg;

  // checks
  noshort_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    vmeSpace == icw_pkg::ICW_AS_SHORT |-> !vmeAccept)
    else $error("short access accepted");
  lockread_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    vmeAccept && vmeRead && !pageNow.normalRead |-> hostLockedRead && !hostPlainRead)
    else $error("locked read missing");
  noflag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    winWr && !regWdata[7] |=> $stable(rangeEn_reg) && $stable(diag_reg))
    else $error("target changed without flag");
  load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    winWr && regWdata[7] && regWdata[5:0] == 6'h05 |=> rangeEn_reg == $past(regWdata[31:14]))
    else $error("range enable not loaded");
  bit6_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    window_reg[6] == 1'b0) else $error("bit 6 set");
  zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    regValid && !regWrite && regAddr == 8'h5C && !targetOk |=> regRdata == 32'h00000000)
    else $error("unmapped select not zero");
  swap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    vmeAccept |-> vmeSwap == pageNow.swap) else $error("swap mismatch");
  parity_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    pageWr && regWdata[4] ##1 pageSel_reg == $past(regWdata[24:9])
    |-> page_mem[pageSel_reg].parity == ^page_mem[pageSel_reg][2:0])
    else $error("page parity wrong");
  plainread_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    vmeAccept && vmeRead && pageNow.normalRead |-> hostPlainRead && !hostLockedRead)
    else $error("plain read missing");
  flagread_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    regValid && !regWrite && regAddr == icw_pkg::WINDOW_OFFSET && targetOk && flag
    |=> regRdata[13:0] == $past(window_reg))
    else $error("window contents not returned");
  resetsel_a: assert property (@(posedge ref_clk)
    !resetn |=> window_reg == icw_pkg::WINDOW_RESET)
    else $error("window not cleared by reset");
  xlatload_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    winWr && regWdata[icw_pkg::WIN_WRITE_BIT] && regWdata[5]
    |=> xlat_reg[$past(regWdata[4:0])] == $past(regWdata[31:14]))
    else $error("translation register not loaded");
  rangegate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    vmeAccept |-> vmeValid && !vmeAddrHigh)
    else $error("vme access accepted out of range");
endmodule
`default_nettype wire

// *** test/icw_host.sv ***
// host model: issues single-cycle accesses on the register port
`timescale 1ns/100ps
`default_nettype none
module icw_host (
  // clock
  input wire logic ref_clk,
  // register request
  output logic regValid,
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [31:0] regWdata
);
  initial begin
    regValid = 1'b0;
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h00000000;
  end
  // select, flag and data leave together in one access; idle lines then invert
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    regValid = 1'b1;
    regWrite = w;
    regAddr = a;
    regWdata = d;
    @(negedge ref_clk);
    regValid = 1'b0;
    regWrite = ~w;
    regAddr = ~a;
    regWdata = ~d;
  endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// testbench: window decode, page table and vme read classification
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic regValid, regWrite, regRvalid, vmeAccept, hostLockedRead, hostPlainRead;
  logic vmeValid, vmeRead, vmeAddrHigh;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [31:0] expQ[$];
  icw_pkg::icw_space_e vmeSpace;
  icw_pkg::icw_swap_e vmeSwap;
  logic [15:0] vmePage;
  logic [15:0] lfsrReg = 16'h8EE6;
  logic [17:0] failData, diagBits;
  logic [32*18-1:0] xlatFlat;
  int bad_count = 0;
  int check_count = 0;
  icw_window u_dut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .regValid(regValid),
    .regWrite(regWrite),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regRdata(regRdata),
    .regRvalid(regRvalid),
    .vmeValid(vmeValid),
    .vmeRead(vmeRead),
    .vmeSpace(vmeSpace),
    .vmeAddrHigh(vmeAddrHigh),
    .vmePage(vmePage),
    .vmeAccept(vmeAccept),
    .hostLockedRead(hostLockedRead),
    .hostPlainRead(hostPlainRead),
    .vmeSwap(vmeSwap),
    .failData(failData),
    .xlatFlat(xlatFlat),
    .diagBits(diagBits)
  );
  icw_host u_host (
    .ref_clk(ref_clk),
    .regValid(regValid),
    .regWrite(regWrite),
    .regAddr(regAddr),
    .regWdata(regWdata)
  );
  always #2 ref_clk = ~ref_clk;
  // pseudo-random words from the shift register
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 16; i++)
      lfsrReg = {lfsrReg[14:0], lfsrReg[15] ^ lfsrReg[13] ^ lfsrReg[12] ^ lfsrReg[10]};
    return {lfsrReg, ~lfsrReg};
  endfunction
  function automatic logic [31:0] ww(logic [17:0] v, logic f, logic [5:0] s);
    return {v, 6'h2A, f, 1'b1, s};
  endfunction
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_host.acc(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    u_host.acc(1'b0, a, 32'h00000000);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // read answers are taken against the oldest note
  always @(negedge ref_clk) begin
    if (regRvalid === 1'b1) begin
      if (expQ.size() == 0) cmp("read note", 32'h1, 32'h0);
      else cmp("read data", expQ.pop_front(), regRdata);
    end
  end
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
  initial begin
    vmeValid = 1'b0;
    vmeRead = 1'b1;
    vmeAddrHigh = 1'b0;
    vmeSpace = icw_pkg::ICW_AS_EXT;
    vmePage = 16'h0000;
    failData = 18'h00000;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    rd(8'h5C, 32'h0);
    // translation registers: load, reselect unflagged, read back
    for (int s = 32; s < 64; s++) begin
      d = rnd();
      wr(8'h5C, ww(d[17:0], 1'b1, 6'(s)));
      wr(8'h5C, ww(~d[17:0], 1'b0, 6'(s)));
      rd(8'h5C, {d[17:0], 14'h0});
      cmp("xlat", 32'(d[17:0]), 32'(xlatFlat[(s-32)*18 +: 18]));
    end
    d = rnd();
    wr(8'h5C, ww(d[17:0], 1'b1, 6'h06));
    rd(8'h5C, {d[17:0], 6'h2A, 2'h2, 6'h06});
    cmp("diag", 32'(d[17:0]), 32'(diagBits));
    failData = d[31:14];
    wr(8'h5C, ww(18'h0, 1'b0, 6'h07));
    rd(8'h5C, {d[31:14], 14'h0});
    // reset in mid-run drops the select back to nothing
    @(negedge ref_clk);
    resetn = 1'b0;
    @(negedge ref_clk);
    resetn = 1'b1;
    rd(8'h5C, 32'h0);
    cmp("diag reset", 32'h0, 32'(diagBits));
    rd(8'h60, 32'h0);
    for (int s = 0; s < 32; s++) begin
      if (s < 5 || s > 7) begin
        wr(8'h5C, ww(18'h3FFFF, 1'b1, 6'(s)));
        rd(8'h5C, 32'h0);
      end
    end
    wr(8'h5C, ww(18'h01000, 1'b1, 6'h05));
    // every attribute code on a fresh page, then a vme read of it
    for (int a = 0; a < 8; a++) begin
      d = rnd();
      @(negedge ref_clk);
      vmeValid = 1'b0;
      vmePage = d[15:0];
      wr(8'h58, {7'h0, vmePage, 5'h01, 1'b0, 3'(a)});
      wr(8'h58, {7'h0, vmePage, 5'h00, 1'b0, 3'h0});
      rd(8'h58, {28'h0, ^3'(a), 3'(a)});
      vmeValid = 1'b1;
      #1;
      cmp("accept", 32'h1, 32'(vmeAccept));
      cmp("plain", 32'(a[2]), 32'(hostPlainRead));
      cmp("locked", 32'(!a[2]), 32'(hostLockedRead));
      cmp("swap", 32'(a[1:0]), 32'(vmeSwap));
    end
    @(negedge ref_clk);
    vmeSpace = icw_pkg::ICW_AS_SHORT;
    #1;
    cmp("short", 32'h0, 32'(vmeAccept));
    @(negedge ref_clk);
    vmeSpace = icw_pkg::ICW_AS_STD;
    #1;
    cmp("std off", 32'h0, 32'(vmeAccept));
    @(negedge ref_clk);
    vmeSpace = icw_pkg::ICW_AS_BAD;
    #1;
    cmp("bad space", 32'h0, 32'(vmeAccept));
    // standard range only: std accepted, ext refused
    wr(8'h5C, ww(18'h00800, 1'b1, 6'h05));
    vmeSpace = icw_pkg::ICW_AS_STD;
    #1;
    cmp("std on", 32'h1, 32'(vmeAccept));
    cmp("std plain", 32'h1, 32'(hostPlainRead));
    @(negedge ref_clk);
    vmeRead = 1'b0;
    #1;
    cmp("write plain", 32'h0, 32'(hostPlainRead));
    cmp("write locked", 32'h0, 32'(hostLockedRead));
    @(negedge ref_clk);
    vmeAddrHigh = 1'b1;
    #1;
    cmp("high addr", 32'h0, 32'(vmeAccept));
    @(negedge ref_clk);
    vmeAddrHigh = 1'b0;
    vmeSpace = icw_pkg::ICW_AS_EXT;
    #1;
    cmp("ext off", 32'h0, 32'(vmeAccept));
    repeat (3) @(negedge ref_clk);
    cmp("pending", 32'h0, 32'(expQ.size()));
    end_of_test();
  end
endmodule
`default_nettype wire
